/* rtl/pmlt_top.sv */
// PCI master latency watchdog with APB register slave
// What this block does
// [R1] Programmed field forms the top five bits of an eight-bit counter.
// [R2] Counter reloads whenever a valid data phase completes.
// [R3] Expiry before next target ready aborts the cycle and raises system error.
// [R4] Retries lasting until expiry also end with a master abort.
// [R5] Zero field disables the counter; no abort from expiry.
// [R6] Control register reads zero after reset; reserved top bits stay zero.
`timescale 1ns/100ps
module pmlt_top
    import pmlt_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_mst_start,
    input wire logic i_mst_end,
    input wire logic i_trdy_n,
    input wire logic i_stop_n,
    output logic o_master_abort,
    output logic o_serr_n,
    output logic o_irq
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] lat_q;
    logic [6:0] ctl1_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_en_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic abort_q;
    logic serr_n_q;
    logic irq_q;
    logic [1:0] trdy_sync_q;
    logic [1:0] stop_sync_q;
    logic retrying_q;
    pmlt_state_t state_q;
    pmlt_state_t state_d;
    logic expired;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // PCI pins are taken as asynchronous, so two stages before use
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            trdy_sync_q <= 2'b11;
            stop_sync_q <= 2'b11;
        end else if (i_ce) begin
            trdy_sync_q <= {trdy_sync_q[0], i_trdy_n};
            stop_sync_q <= {stop_sync_q[0], i_stop_n};
        end
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic apb_acc = i_psel && i_penable && !pready_q;
    // Writes land on the completing edge, the one where the master sees pready
    wire logic apb_done = i_psel && i_penable && pready_q;
    wire logic apb_wr = apb_done && i_pwrite;
    wire logic hit_lat = i_paddr == PMLT_LAT_OFFS;
    wire logic hit_ctl1 = i_paddr == PMLT_CTL1_OFFS;
    wire logic hit_stat = i_paddr == PMLT_IRQ_STAT_OFFS;
    wire logic hit_en = i_paddr == PMLT_IRQ_EN_OFFS;
    wire logic hit_clr = i_paddr == PMLT_IRQ_CLR_OFFS;
    wire logic hit_sts = i_paddr == PMLT_STAT_OFFS;
    wire logic hit_any = hit_lat | hit_ctl1 | hit_stat | hit_en | hit_clr | hit_sts;
    wire logic [31:0] rd_mux =
        hit_lat ? {24'h000000, lat_q} :
        hit_ctl1 ? {25'h0000000, ctl1_q} :
        hit_stat ? {30'h00000000, irq_stat_q} :
        hit_en ? {30'h00000000, irq_en_q} :
        hit_sts ? {29'h00000000, state_q} : 32'h00000000;

    // One wait state: answer lands the cycle after access phase begins
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (i_ce) begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !hit_any;
            prdata_q <= (apb_acc && !i_pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // [R6] Reset to zero, reserved bits forced low
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            lat_q <= PMLT_LAT_RST;
            ctl1_q <= PMLT_CTL1_RST[6:0];
            irq_en_q <= PMLT_IRQ_RST;
        end else if (i_ce && apb_wr) begin
            if (hit_lat) begin
                lat_q <= i_pwdata[7:0] & PMLT_LAT_WMASK;
            end
            if (hit_ctl1) begin
                ctl1_q <= i_pwdata[6:0] & PMLT_CTL1_WMASK;
            end
            if (hit_en) begin
                irq_en_q <= i_pwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Watchdog sequencing
    // ------------------------------------------------------------------
    wire logic [4:0] field = lat_q[PMLT_FIELD_LSB+PMLT_FIELD_W-4 -: PMLT_FIELD_W];
    // [R5] Zero field keeps the counter off
    wire logic wd_on = field != 5'h00;
    wire logic in_run = state_q == PMLT_RUN;
    // [R2] Valid data phase seen on synced target ready
    wire logic data_phase = in_run && !trdy_sync_q[1];
    wire logic cnt_load = (state_q == PMLT_IDLE && i_mst_start) || data_phase;
    wire logic retry_seen = in_run && !stop_sync_q[1] && trdy_sync_q[1];
    wire logic abort_now = in_run && wd_on && expired;

    pmlt_counter u_counter (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_field(field),
        .i_load(cnt_load),
        .i_run(in_run && wd_on),
        .o_expired(expired)
    );

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            PMLT_IDLE: begin
                if (i_mst_start) begin
                    state_d = PMLT_RUN;
                end
            end
            PMLT_RUN: begin
                if (abort_now) begin
                    state_d = PMLT_ABORT;
                end else if (i_mst_end) begin
                    state_d = PMLT_IDLE;
                end
            end
            PMLT_ABORT: begin
                state_d = PMLT_IDLE;
            end
            default: begin
                state_d = PMLT_IDLE;
            end
        endcase
    end

    // [R3] Abort and system error on expiry
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= PMLT_IDLE;
            abort_q <= 1'b0;
            serr_n_q <= 1'b1;
            retrying_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            abort_q <= abort_now;
            serr_n_q <= !abort_now;
            retrying_q <= in_run ? (retry_seen || (retrying_q && trdy_sync_q[1])) : 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // [R4] Retry-caused aborts get their own sticky bit
    wire logic [1:0] ev_set = {abort_now && retrying_q, abort_now && !retrying_q};
    wire logic [1:0] ev_clr = (apb_wr && hit_clr) ? i_pwdata[1:0] : 2'b00;

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_stat_q <= PMLT_IRQ_RST;
            irq_q <= 1'b0;
        end else if (i_ce) begin
            irq_stat_q <= (irq_stat_q & ~ev_clr) | ev_set;
            irq_q <= |(((irq_stat_q & ~ev_clr) | ev_set) & irq_en_q);
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_master_abort = abort_q;
    assign o_serr_n = serr_n_q;
    assign o_irq = irq_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_expire;
        i_ce && in_run && wd_on && expired;
    endsequence
    // [R3] Expiry gives abort and error
    chk_abort_on_expiry: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R3]
        s_expire |=> (o_master_abort && !o_serr_n))
        else $error("expiry did not abort");
    // [R5] Zero field never aborts
    chk_zero_no_abort: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R5]
        (field == 5'h00) |=> !o_master_abort)
        else $error("abort with watchdog off");
    // [R6] Reserved bits stay low
    chk_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R6]
        lat_q[7:5] == 3'b000)
        else $error("reserved bits set");
    // [R2] Data phase reloads, no abort next cycle
    chk_reload_phase: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R2]
        (i_ce && data_phase && field != 5'h00) |=> !(in_run && expired))
        else $error("no reload on data phase");
    // [R4] Retry abort flagged
    chk_retry_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R4]
        (s_expire and retrying_q) |=> irq_stat_q[PMLT_EV_RETRY])
        else $error("retry abort not flagged");
    // [R1] No abort in the cycle right after a counter load
    chk_min_wait: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R1]
        (i_ce && cnt_load) |=> !abort_now)
        else $error("abort too soon");
endmodule

/* shared/pmlt_pkg.sv */
// Package: register map, field layout and constants of the PCI master latency watchdog
package pmlt_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] PMLT_LAT_OFFS = 8'h0D;
    localparam logic [7:0] PMLT_CTL1_OFFS = 8'h40;
    localparam logic [7:0] PMLT_IRQ_STAT_OFFS = 8'h44;
    localparam logic [7:0] PMLT_IRQ_EN_OFFS = 8'h48;
    localparam logic [7:0] PMLT_IRQ_CLR_OFFS = 8'h4C;
    localparam logic [7:0] PMLT_STAT_OFFS = 8'h50;
    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int PMLT_FIELD_LSB = 3;
    localparam int PMLT_FIELD_W = 5;
    localparam logic [7:0] PMLT_LAT_RST = 8'h00;
    localparam logic [7:0] PMLT_CTL1_RST = 8'h00;
    localparam logic [7:0] PMLT_LAT_WMASK = 8'h1F;
    localparam logic [6:0] PMLT_CTL1_WMASK = 7'h7F;
    localparam int PMLT_EV_TOUT = 0;
    localparam int PMLT_EV_RETRY = 1;
    localparam logic [1:0] PMLT_IRQ_RST = 2'h0;
    localparam logic [7:0] PMLT_CNT_RST = 8'h00;
    // State machine
    typedef enum logic [2:0] {
        PMLT_IDLE = 3'b001,
        PMLT_RUN = 3'b010,
        PMLT_ABORT = 3'b100
    } pmlt_state_t;
endpackage

/* rtl/pmlt_counter.sv */
// Eight-bit countdown counter with hardware-supplied low bits
`timescale 1ns/100ps
module pmlt_counter
    import pmlt_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [4:0] i_field,
    input wire logic i_load,
    input wire logic i_run,
    output logic o_expired
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    wire logic [7:0] start_val;
    // ------------------------------------------------------------------
    // Count logic
    // ------------------------------------------------------------------
    // [R1] Field is upper five bits
    assign start_val = {i_field, 3'b111};
    assign cnt_d = i_load ? start_val : (i_run && cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
    assign o_expired = i_run && !i_load && (cnt_q == 8'h00);

    // Counter register
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= PMLT_CNT_RST;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
        end
    end

    // [R1] Load takes the full eight bits
    chk_load_start_value: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R1]
        (i_ce && i_load) |=> cnt_q == $past(start_val))
        else $error("counter did not load start value");
endmodule

/* sim/pmlt_target_model.sv */
// Behavioural PCI target facing the watched master cycles
`timescale 1ns/100ps
module pmlt_target_model (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [1:0] i_mode,
    output logic o_trdy_n,
    output logic o_stop_n
);
    // ------------------------------------------------------------------
    // Target behaviour
    // ------------------------------------------------------------------
    logic [1:0] phase_q;
    // Mode 0 silent, 1 ready every fourth cycle, 2 endless retry
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_q <= 2'h0;
            o_trdy_n <= 1'b1;
            o_stop_n <= 1'b1;
        end else begin
            phase_q <= phase_q + 2'h1;
            // Undriven pins float back to the pull-up level
            o_trdy_n <= !(i_mode == 2'h1 && phase_q == 2'h3);
            o_stop_n <= (i_mode != 2'h2);
        end
    end
endmodule

/* sim/pmlt_bench.sv */
// Self-checking bench of the latency watchdog
`timescale 1ns/100ps
module pmlt_bench;
    import pmlt_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus, model and design
    // ------------------------------------------------------------------
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mst_start = 1'b0, mst_end = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, abort, serr_n, irq, trdy_n, stop_n;
    logic [1:0] mode = 2'h0;
    logic ce = 1'b1;
    logic [31:0] lfsr_q = 32'h000185C4;
    int n_errors = 0;
    int checks_done = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    pmlt_target_model tgt (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_mode(mode),
        .o_trdy_n(trdy_n), .o_stop_n(stop_n));
    pmlt_top dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(ce), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_mst_start(mst_start),
        .i_mst_end(mst_end), .i_trdy_n(trdy_n), .i_stop_n(stop_n),
        .o_master_abort(abort), .o_serr_n(serr_n), .o_irq(irq));
    // Compare, bus and run helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk_sys);
        penable <= 1'b1;
        // No fixed latency assumed; polling gives up after 1000 cycles and counts an error
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 1000);
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        chk({31'h0, err}, 32'h0);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, experr});
    endtask
    function automatic int abort_delay(input logic [4:0] f);
        // Start edge loads {field,111}; abort edge follows zero, bench sees it one edge on
        return f * 8 + 9;
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic run_case(input logic [1:0] m, input int stall, input int exp);
        int n;
        n = 0;
        mode <= m;
        @(posedge i_clk_sys);
        mst_start <= 1'b1;
        @(posedge i_clk_sys);
        mst_start <= 1'b0;
        // Optional clock-enable stall just after the start is taken
        ce <= (stall == 0);
        // Give up at 400 cycles; beyond every programmable limit
        while (abort !== 1'b1 && n < 400) begin
            @(posedge i_clk_sys);
            n++;
            if (n == stall) ce <= 1'b1;
        end
        chk(n, exp);
        if (n < 400) chk({31'h0, serr_n}, 32'h0);
        mst_end <= 1'b1;
        mode <= 2'h0;
        @(posedge i_clk_sys);
        mst_end <= 1'b0;
    endtask
    task automatic summarize();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [4:0] f;
        repeat (8) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd_chk(PMLT_LAT_OFFS, {24'h0, PMLT_LAT_RST}, 1'b0);
        rd_chk(PMLT_CTL1_OFFS, {24'h0, PMLT_CTL1_RST}, 1'b0);
        rd_chk(PMLT_STAT_OFFS, 32'h1, 1'b0);
        rd_chk(8'h20, 32'h0, 1'b1);
        wr(PMLT_CTL1_OFFS, 32'h7F);
        rd_chk(PMLT_CTL1_OFFS, 32'h7F, 1'b0);
        wr(PMLT_LAT_OFFS, 32'h1F);
        rd_chk(PMLT_LAT_OFFS, 32'h1F, 1'b0);
        wr(PMLT_IRQ_STAT_OFFS, 32'h3);
        rd_chk(PMLT_IRQ_STAT_OFFS, 32'h0, 1'b0);
        wr(PMLT_IRQ_EN_OFFS, 32'h0);
        wr(PMLT_LAT_OFFS, 32'h01);
        run_case(2'h0, 0, abort_delay(5'h01));
        rd_chk(PMLT_IRQ_STAT_OFFS, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wr(PMLT_IRQ_EN_OFFS, 32'h3);
        rd_chk(PMLT_STAT_OFFS, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h1);
        wr(PMLT_IRQ_CLR_OFFS, 32'h1);
        rd_chk(PMLT_IRQ_STAT_OFFS, 32'h0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        run_case(2'h2, 0, abort_delay(5'h01));
        rd_chk(PMLT_IRQ_STAT_OFFS, 32'h2, 1'b0);
        wr(PMLT_IRQ_CLR_OFFS, 32'h2);
        run_case(2'h1, 0, 400);
        wr(PMLT_LAT_OFFS, 32'h00);
        run_case(2'h0, 0, 400);
        // Random fields, never zero, reserved bits written as zero
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            f = lfsr_q[4:0] | 5'h01;
            wr(PMLT_LAT_OFFS, {27'h0, f});
            // First pass freezes the block for five cycles, pushing the abort out
            run_case(2'h0, (i == 0) ? 5 : 0, abort_delay(f) + ((i == 0) ? 5 : 0));
        end
        summarize();
    end
    // Hang guard, well past the expected run length
    initial begin
        #(25 * 30000);
        n_errors++;
        summarize();
    end
endmodule
